//--- common/fdc_pkg.sv
// constants, types and field layout for the four channel dma controller
// Notes on behaviour
// - four channels, two A/B groups, pairs combine
// - dual short mode: one 24-bit, one 16-bit address
// - single mode: one 24-bit address, one cycle
// - sequential: unit per request, step 1/2
// - count exhausted raises cpu or dtu request
// - idle mode keeps both addresses fixed
// - repeat: 1..256, reload address and count
// - repeat mode never raises completion request
// - short mode direction chosen by software
// - single address only on B channels
// - single mode supports sequential, idle, repeat
// - single mode strobes device with acknowledge
// - full mode: two 24-bit addresses, two channels
// - full normal: external or auto request
// - auto request latched, runs to count
// - auto request: burst or cycle steal
// - block mode: 1..256 units, 1..65536 blocks
// - block end reloads block area address
// - block select zero makes B side area
// - block mode started by timer, serial, adc, pin
// - byte or word unit per channel, a full mode pair uses the A channel setting
package fdc_pkg;
    localparam int NCH = 4;
    // register byte offsets; channel c adds c << CH_SHIFT
    localparam int CH_SHIFT = 4;
    localparam logic [7:0] REG_MEM = 8'h00;
    localparam logic [7:0] REG_IO = 8'h04;
    localparam logic [7:0] REG_CNT = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h40;
    localparam logic [7:0] REG_GRP0 = 8'h44;
    localparam logic [7:0] REG_GRP1 = 8'h48;
    // channel control fields
    localparam int CB_EN = 0;
    localparam int CB_WORD = 1;
    localparam int CB_DIR = 2;
    localparam int CB_SUB_LO = 3;
    localparam int CB_SINGLE = 5;
    localparam int CB_DEC = 6;
    localparam int CB_IE = 7;
    localparam int CB_DTU = 8;
    localparam int CB_SRC_LO = 9;
    localparam int CTRL_W = 13;
    localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
    localparam logic [1:0] SUB_SEQ = 2'h0;
    localparam logic [1:0] SUB_IDLE = 2'h1;
    localparam logic [1:0] SUB_REP = 2'h2;
    // group control fields
    localparam int GB_FULL = 0;
    localparam int GB_BLOCK = 1;
    localparam int GB_AREA = 2;
    localparam int GB_AUTO = 3;
    localparam int GB_BURST = 4;
    localparam int GRP_W = 5;
    localparam logic [GRP_W-1:0] GRP_RST = 5'h00;
    // activation source codes 0..5 are timer channels
    localparam logic [3:0] SRC_EXT = 4'hB;
    localparam logic [7:0] IO_PAGE = 8'hFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [7:0] LOW_ONE = 8'h01;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b10,
        ST_SINGLE = 2'b11
    } fdc_state_e;

    typedef struct packed {
        logic [23:0] addr;
        logic we;
        logic word;
        logic [15:0] wdata;
    } fdc_bus_s;
endpackage

//--- hw/fdc_dma.sv
// four channel dma controller with apb register slave and system bus master
module fdc_dma import fdc_pkg::*; (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // system bus master
    output logic BUS_REQ_O,
    output logic BUS_LOCK_O,
    output fdc_bus_s BUS_O,
    input wire logic [15:0] BUS_RDATA_I,
    input wire logic BUS_ACK_I,
    // external devices
    input wire logic [NCH-1:0] EXT_REQ_I,
    output logic [NCH-1:0] TRANSFER_ACKNOWLEDGE_STROBE_O,
    // on-chip activation sources, one-cycle pulses
    input wire logic [5:0] TIMER_PULSE_UNIT_MATCH_I,
    input wire logic [1:0] SERIAL_PORT_TX_I,
    input wire logic [1:0] SERIAL_PORT_RX_I,
    input wire logic ADC_END_I,
    // completion requests
    output logic [NCH-1:0] IRQ_CPU_O,
    output logic [NCH-1:0] IRQ_DESCRIPTOR_TRANSFER_UNIT_O
);
    logic [23:0] mem_reg [NCH];
    logic [23:0] mem_init_reg [NCH];
    logic [15:0] io_reg [NCH];
    logic [15:0] cnt_reg [NCH];
    logic [15:0] cnt_init_reg [NCH];
    logic [CTRL_W-1:0] ctrl_reg [NCH];
    logic [GRP_W-1:0] grp_reg [2];
    logic [NCH-1:0] done_reg, pend_reg, strobe_reg;
    logic [NCH-1:0] ext_s1_reg, ext_s2_reg, ext_s3_reg;
    fdc_state_e state_reg;
    logic [1:0] cur_reg;
    logic lock_reg;
    logic [23:0] addr_reg;
    logic we_reg, word_reg;
    logic [15:0] data_reg;
    logic [31:0] prdata_reg;

    function automatic logic [23:0] step(input logic [23:0] a, input logic word,
                                        input logic dec);
        logic [23:0] d;
        d = word ? 24'h000002 : 24'h000001;
        step = dec ? a - d : a + d;
    endfunction

    function automatic logic [1:0] prio(input logic [NCH-1:0] r);
        prio = r[0] ? 2'h0 : r[1] ? 2'h1 : r[2] ? 2'h2 : 2'h3;
    endfunction

    // apb decode
    wire apb_setup = PSEL_I & ~PENABLE_I;
    wire apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
    wire aligned = (PADDR_I[1:0] == 2'b00);
    wire hit_ch = aligned && (PADDR_I < REG_STAT);
    wire hit_stat = (PADDR_I == REG_STAT);
    wire hit_grp0 = (PADDR_I == REG_GRP0);
    wire hit_grp1 = (PADDR_I == REG_GRP1);
    wire mapped = hit_ch | hit_stat | hit_grp0 | hit_grp1;
    wire [1:0] a_ch = PADDR_I[CH_SHIFT+1:CH_SHIFT];
    wire [7:0] a_off = {4'h0, PADDR_I[3:0]};
    wire [NCH-1:0] en_vec = {ctrl_reg[3][CB_EN], ctrl_reg[2][CB_EN],
                             ctrl_reg[1][CB_EN], ctrl_reg[0][CB_EN]};
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
    assign PRDATA_O = prdata_reg;

    // read selection
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h00000000;
        if (hit_ch && a_off == REG_MEM) begin
            rd_val = {8'h00, mem_reg[a_ch]};
        end else if (hit_ch && a_off == REG_IO) begin
            rd_val = {16'h0000, io_reg[a_ch]};
        end else if (hit_ch && a_off == REG_CNT) begin
            rd_val = {16'h0000, cnt_reg[a_ch]};
        end else if (hit_ch) begin
            rd_val = {19'h00000, ctrl_reg[a_ch]};
        end else if (hit_stat) begin
            rd_val = {24'h000000, en_vec, done_reg};
        end else if (hit_grp0) begin
            rd_val = {27'h0000000, grp_reg[0]};
        end else if (hit_grp1) begin
            rd_val = {27'h0000000, grp_reg[1]};
        end
    end

    // per channel request decode
    logic [NCH-1:0] req, pend_set, full_vec, ext_edge;
    assign ext_edge = ext_s2_reg & ~ext_s3_reg;
    for (genvar c = 0; c < NCH; c++) begin : g_req
        wire [15:0] tv = {4'h0, ext_edge[c], ADC_END_I, SERIAL_PORT_RX_I,
                          SERIAL_PORT_TX_I, TIMER_PULSE_UNIT_MATCH_I};
        wire [GRP_W-1:0] gr = grp_reg[c/2];
        wire auto_on = gr[GB_FULL] & ~gr[GB_BLOCK] & gr[GB_AUTO] & (c % 2 == 0);
        assign full_vec[c] = gr[GB_FULL];
        assign pend_set[c] = ctrl_reg[c][CB_EN] &
                             (tv[ctrl_reg[c][CB_SRC_LO+3:CB_SRC_LO]] | auto_on);
        assign req[c] = pend_reg[c] & ctrl_reg[c][CB_EN] &
                        (~gr[GB_FULL] | (c % 2 == 0));
    end

    // arbitration, a locked channel keeps the bus
    wire [NCH-1:0] cur_hot = 4'h1 << cur_reg;
    wire [NCH-1:0] req_eff = lock_reg ? (req & cur_hot) : req;
    wire [1:0] grant = prio(req_eff);
    wire [1:0] ech = (state_reg == ST_IDLE) ? grant : cur_reg;
    wire [1:0] ea = {ech[1], 1'b0};
    wire [1:0] eb = {ech[1], 1'b1};
    wire [CTRL_W-1:0] ec = ctrl_reg[ech];
    wire efull = full_vec[ech];
    wire esingle = ec[CB_SINGLE] & ~efull;
    wire [23:0] e_io = {IO_PAGE, io_reg[ech]};
    wire [23:0] src_addr = efull ? mem_reg[ea] : (ec[CB_DIR] ? e_io : mem_reg[ech]);
    wire [23:0] dst_addr = efull ? mem_reg[eb] : (ec[CB_DIR] ? mem_reg[ech] : e_io);

    // completion bookkeeping for the channel on the bus
    wire fin = BUS_ACK_I & ((state_reg == ST_WRITE) | (state_reg == ST_SINGLE));
    wire [1:0] ca = {cur_reg[1], 1'b0};
    wire [1:0] cb = {cur_reg[1], 1'b1};
    wire [GRP_W-1:0] cg = grp_reg[cur_reg[1]];
    wire cfull = cg[GB_FULL];
    wire cblk = cfull & cg[GB_BLOCK];
    wire [1:0] pch = cfull ? ca : cur_reg;
    wire [CTRL_W-1:0] cc = ctrl_reg[pch];
    wire [CTRL_W-1:0] cbc = ctrl_reg[cb];
    wire [1:0] csub = cc[CB_SUB_LO+1:CB_SUB_LO];
    wire crep = ~cfull & (csub == SUB_REP);
    wire last_s = crep ? (cnt_reg[pch][7:0] == LOW_ONE) : (cnt_reg[pch] == CNT_ONE);
    wire blk_end = ~cblk | (cnt_reg[cb][7:0] == LOW_ONE);
    wire last_f = blk_end & (cnt_reg[ca] == CNT_ONE);
    wire clast = cfull ? last_f : last_s;
    wire cdone = clast & ~crep;
    wire pend_clr = cfull ? blk_end : 1'b1;
    wire nx_lock = cfull & ~last_f & (cblk ? ~blk_end : (cg[GB_AUTO] & cg[GB_BURST]));
    logic [23:0] nx_mem_p, nx_mem_s;
    logic [15:0] nx_cnt_p, nx_cnt_s;
    always_comb begin
        nx_mem_s = mem_reg[cb];
        nx_cnt_s = cnt_reg[cb];
        if (!cfull) begin
            nx_mem_p = (csub == SUB_IDLE) ? mem_reg[pch] :
                       step(mem_reg[pch], cc[CB_WORD], cc[CB_DEC]);
            nx_cnt_p = cnt_reg[pch] - 16'h0001;
            if (crep && last_s) begin
                nx_mem_p = mem_init_reg[pch];
                nx_cnt_p = cnt_init_reg[pch];
            end
        end else begin
            nx_mem_p = (csub == SUB_IDLE) ? mem_reg[ca] :
                       step(mem_reg[ca], cc[CB_WORD], cc[CB_DEC]);
            nx_mem_s = (cbc[CB_SUB_LO+1:CB_SUB_LO] == SUB_IDLE) ? mem_reg[cb] :
                       step(mem_reg[cb], cc[CB_WORD], cbc[CB_DEC]);
            if (cblk && blk_end && cg[GB_AREA]) begin
                nx_mem_p = mem_init_reg[ca];
            end
            if (cblk && blk_end && !cg[GB_AREA]) begin
                nx_mem_s = mem_init_reg[cb];
            end
            nx_cnt_p = blk_end ? cnt_reg[ca] - 16'h0001 : cnt_reg[ca];
            if (cblk) begin
                nx_cnt_s = blk_end ? cnt_init_reg[cb] : cnt_reg[cb] - 16'h0001;
            end
        end
    end

    // channel registers: engine update wins over a software write
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int c = 0; c < NCH; c++) begin
                mem_reg[c] <= 24'h000000;
                mem_init_reg[c] <= 24'h000000;
                io_reg[c] <= 16'h0000;
                cnt_reg[c] <= 16'h0000;
                cnt_init_reg[c] <= 16'h0000;
                ctrl_reg[c] <= CTRL_RST;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (fin && pch == 2'(c)) begin
                    mem_reg[c] <= nx_mem_p;
                    cnt_reg[c] <= nx_cnt_p;
                    if (cdone) ctrl_reg[c][CB_EN] <= 1'b0;
                end else if (fin && cfull && cb == 2'(c)) begin
                    mem_reg[c] <= nx_mem_s;
                    cnt_reg[c] <= nx_cnt_s;
                end else if (apb_wr && hit_ch && a_ch == 2'(c)) begin
                    if (a_off == REG_MEM) begin
                        mem_reg[c] <= PWDATA_I[23:0];
                        mem_init_reg[c] <= PWDATA_I[23:0];
                    end else if (a_off == REG_IO) begin
                        io_reg[c] <= PWDATA_I[15:0];
                    end else if (a_off == REG_CNT) begin
                        cnt_reg[c] <= PWDATA_I[15:0];
                        cnt_init_reg[c] <= PWDATA_I[15:0];
                    end else begin
                        ctrl_reg[c] <= PWDATA_I[CTRL_W-1:0] &
                                       ~(CTRL_W'(c % 2 == 0) << CB_SINGLE);
                    end
                end
            end
        end
    end

    // group control, status flags and pin synchroniser; set wins over clear
    wire [NCH-1:0] done_set = (fin && cdone) ? (4'h1 << pch) : 4'h0;
    wire [NCH-1:0] done_clr = (apb_wr && hit_stat) ? PWDATA_I[3:0] : 4'h0;
    wire [NCH-1:0] pend_off = (fin && pend_clr) ? (4'h1 << pch) : 4'h0;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            grp_reg[0] <= GRP_RST;
            grp_reg[1] <= GRP_RST;
            done_reg <= 4'h0;
            pend_reg <= 4'h0;
            ext_s1_reg <= 4'h0;
            ext_s2_reg <= 4'h0;
            ext_s3_reg <= 4'h0;
            prdata_reg <= 32'h00000000;
        end else begin
            if (apb_wr && hit_grp0) grp_reg[0] <= PWDATA_I[GRP_W-1:0];
            if (apb_wr && hit_grp1) grp_reg[1] <= PWDATA_I[GRP_W-1:0];
            done_reg <= (done_reg & ~done_clr) | done_set;
            pend_reg <= ((pend_reg & ~pend_off) | pend_set) & en_vec;
            ext_s1_reg <= EXT_REQ_I;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            if (apb_setup) prdata_reg <= rd_val;
        end
    end

    // completion request routing
    for (genvar c = 0; c < NCH; c++) begin : g_irq
        assign IRQ_CPU_O[c] = done_reg[c] & ctrl_reg[c][CB_IE] & ~ctrl_reg[c][CB_DTU];
        assign IRQ_DESCRIPTOR_TRANSFER_UNIT_O[c] = done_reg[c] & ctrl_reg[c][CB_IE] &
                                                   ctrl_reg[c][CB_DTU];
    end

    // transfer engine
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg <= ST_IDLE;
            cur_reg <= 2'h0;
            lock_reg <= 1'b0;
            addr_reg <= 24'h000000;
            we_reg <= 1'b0;
            word_reg <= 1'b0;
            data_reg <= 16'h0000;
            strobe_reg <= 4'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (|req_eff) begin
                        cur_reg <= grant;
                        word_reg <= ec[CB_WORD];
                        if (esingle) begin
                            addr_reg <= mem_reg[ech];
                            we_reg <= ec[CB_DIR];
                            strobe_reg <= 4'h1 << grant;
                            state_reg <= ST_SINGLE;
                        end else begin
                            addr_reg <= src_addr;
                            we_reg <= 1'b0;
                            state_reg <= ST_READ;
                        end
                    end else begin
                        lock_reg <= 1'b0;
                    end
                end
                ST_READ: begin
                    if (BUS_ACK_I) begin
                        data_reg <= BUS_RDATA_I;
                        addr_reg <= dst_addr;
                        we_reg <= 1'b1;
                        state_reg <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (BUS_ACK_I) begin
                        lock_reg <= nx_lock;
                        we_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_SINGLE: begin
                    if (BUS_ACK_I) begin
                        lock_reg <= nx_lock;
                        we_reg <= 1'b0;
                        strobe_reg <= 4'h0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign BUS_REQ_O = (state_reg != ST_IDLE);
    assign BUS_LOCK_O = lock_reg;
    assign BUS_O = '{addr: addr_reg, we: we_reg, word: word_reg, wdata: data_reg};
    assign TRANSFER_ACKNOWLEDGE_STROBE_O = strobe_reg;

    // checks
    wire [23:0] cur_mem = mem_reg[pch];
    wire [23:0] cur_init = mem_init_reg[pch];
    wire [23:0] cur_bmem = mem_reg[cb];
    wire [23:0] cur_binit = mem_init_reg[cb];
    default clocking cb_clk @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    AST_SINGLE_ONE_CYCLE: assert property (
        state_reg == ST_SINGLE && BUS_ACK_I |=> state_reg == ST_IDLE && strobe_reg == 4'h0)
        else $error("single transfer took more than one bus cycle");
    AST_SEQ_STEP: assert property (
        fin && !cfull && csub == SUB_SEQ && !last_s && !cc[CB_DEC]
        |=> cur_mem == $past(cur_mem) + (cc[CB_WORD] ? 24'h000002 : 24'h000001))
        else $error("sequential step is not plus one or two");
    AST_IDLE_FIXED: assert property (
        fin && !cfull && csub == SUB_IDLE |=> $stable(cur_mem))
        else $error("idle mode moved the memory address");
    AST_REPEAT_RELOAD: assert property (
        fin && crep && last_s |=> cur_mem == cur_init && ctrl_reg[pch][CB_EN])
        else $error("repeat mode did not reload");
    AST_REPEAT_NO_IRQ: assert property (
        fin && crep && !done_reg[pch] |=> !done_reg[pch])
        else $error("repeat mode raised completion");
    AST_A_NO_SINGLE: assert property (
        !ctrl_reg[0][CB_SINGLE] && !ctrl_reg[2][CB_SINGLE])
        else $error("single address set on an A channel");
    AST_STROBE_ONLY_SINGLE: assert property (
        strobe_reg != 4'h0 |-> state_reg == ST_SINGLE && $onehot(strobe_reg))
        else $error("acknowledge strobe outside a single cycle");
    AST_DONE_SETS: assert property (
        fin && cdone |=> done_reg[$past(pch)] && !ctrl_reg[$past(pch)][CB_EN])
        else $error("count exhausted without completion flag");
    AST_BLOCK_RELOAD: assert property (
        fin && cblk && blk_end && !cg[GB_AREA] |=> cur_bmem == cur_binit)
        else $error("block area address not reloaded");
    AST_PRIORITY: assert property (
        state_reg == ST_IDLE && !lock_reg && req[0] |=> cur_reg == 2'h0)
        else $error("highest priority channel not granted");
    COV_SINGLE: cover property (state_reg == ST_SINGLE && BUS_ACK_I);
    COV_REPEAT_WRAP: cover property (fin && crep && last_s);
    COV_BLOCK_END: cover property (fin && cblk && blk_end);
    COV_BURST: cover property (lock_reg && state_reg == ST_READ);
endmodule // fdc_dma

//--- tb/fdc_dma_test.sv
// self-checking bench for the four channel dma controller
module fdc_dma_test import fdc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, bus_req, bus_lock, bus_ack, err;
    fdc_bus_s bus;
    logic [15:0] bus_rdata;
    logic [NCH-1:0] strobe, irq_cpu, irq_dtu;
    logic [5:0] timer = 6'h00;
    logic [NCH-1:0] ext = 4'h0;
    int n_lock = 0;
    int n_mismatch = 0;
    int compares = 0;
    // 50 MHz clock
    always #10 clk = !clk;
    // cycles with the system bus held between units
    always @(posedge clk) if (bus_lock) n_lock <= n_lock + 1;
    fdc_dma fdc_dma_i (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .BUS_REQ_O(bus_req), .BUS_LOCK_O(bus_lock),
        .BUS_O(bus), .BUS_RDATA_I(bus_rdata), .BUS_ACK_I(bus_ack), .EXT_REQ_I(ext),
        .TRANSFER_ACKNOWLEDGE_STROBE_O(strobe), .TIMER_PULSE_UNIT_MATCH_I(timer),
        .SERIAL_PORT_TX_I(2'h0), .SERIAL_PORT_RX_I(2'h0), .ADC_END_I(1'b0),
        .IRQ_CPU_O(irq_cpu), .IRQ_DESCRIPTOR_TRANSFER_UNIT_O(irq_dtu));
    fdc_mem_model fdc_mem_model_i (.clk_i(clk), .rst_i(rst), .bus_req_i(bus_req),
        .bus_i(bus), .strobe_i(strobe), .rdata_o(bus_rdata), .ack_o(bus_ack));
    // verdict and end of run
    task automatic stop_test();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // pulse one timer source (or pin 0 for src 6 and up) and wait for bus answers
    task automatic pulse(input int src, input int acks);
        int n0, n;
        n0 = fdc_mem_model_i.n_ack;
        if (src < 6) timer[src] <= 1'b1;
        else ext[0] <= 1'b1;
        @(posedge clk);
        timer <= 6'h00;
        ext <= 4'h0;
        n = 0;
        while ((fdc_mem_model_i.n_ack < n0 + acks || bus_req) && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) begin
            n_mismatch++;
            stop_test();
        end
        @(posedge clk);
    endtask
    task automatic t_regs();
        apb(0, REG_CTRL, 0);
        chk(rd, 32'(CTRL_RST), "ctrl reset value");
        apb(0, REG_GRP1, 0);
        chk(rd, 32'(GRP_RST), "group reset value");
        apb(1, REG_CTRL, 32'h20);
        apb(0, REG_CTRL, 0);
        chk(rd, 32'h0, "single kept off on A");
        apb(1, REG_CTRL + 8'h10, 32'h20);
        apb(0, REG_CTRL + 8'h10, 0);
        chk(rd, 32'h20, "single allowed on B");
        apb(1, REG_CTRL + 8'h10, 0);
        apb(0, 8'h50, 0);
        chk({31'h0, err} | rd, 32'h1, "unmapped read");
        $display("register test done");
    endtask
    task automatic t_seq();
        apb(1, REG_MEM, 32'h10);
        apb(1, REG_IO, 32'h20);
        apb(1, REG_CNT, 32'h2);
        apb(1, REG_CTRL, 32'h81);
        pulse(0, 2);
        apb(0, REG_MEM, 0);
        chk(rd, 32'h11, "address step one");
        chk(32'(irq_cpu), 32'h0, "no early completion");
        pulse(0, 2);
        chk(32'(fdc_mem_model_i.last_addr), 32'hFF0020, "short side address");
        chk(32'(fdc_mem_model_i.mem[8'h20]), 32'h4B, "moved byte");
        chk(32'(irq_cpu), 32'h1, "completion to cpu");
        apb(0, REG_STAT, 0);
        chk(32'(rd[7:0]), 32'h01, "done set, enable cleared");
        apb(1, REG_STAT, 32'h1);
        chk(32'(irq_cpu), 32'h0, "completion cleared");
        $display("sequential test done");
    endtask
    task automatic t_rep();
        apb(1, REG_MEM + 8'h10, 32'h30);
        apb(1, REG_IO + 8'h10, 32'h40);
        apb(1, REG_CNT + 8'h10, 32'h2);
        apb(1, REG_CTRL + 8'h10, 32'h291);
        pulse(1, 2);
        pulse(1, 2);
        apb(0, REG_MEM + 8'h10, 0);
        chk(rd, 32'h30, "address reloaded");
        apb(0, REG_STAT, 0);
        chk(32'(rd[7:0]), 32'h20, "no done, still enabled");
        chk(32'(irq_cpu), 32'h0, "no completion request");
        pulse(1, 2);
        apb(0, REG_MEM + 8'h10, 0);
        chk(rd, 32'h31, "keeps running");
        apb(1, REG_CTRL + 8'h10, 0);
        $display("repeat test done");
    endtask
    task automatic t_single();
        int n0;
        apb(1, REG_MEM + 8'h10, 32'h50);
        apb(1, REG_CNT + 8'h10, 32'h1);
        apb(1, REG_CTRL + 8'h10, 32'h5A9);
        n0 = fdc_mem_model_i.n_ack;
        pulse(2, 1);
        chk(32'(fdc_mem_model_i.n_ack - n0), 32'h1, "one bus cycle");
        chk(32'(fdc_mem_model_i.last_addr), 32'h50, "memory address");
        chk(32'(fdc_mem_model_i.last_strobe), 32'h2, "strobe on B");
        chk(32'(fdc_mem_model_i.dev_data[7:0]), 32'h0A, "device data");
        chk(32'(irq_dtu), 32'h2, "completion to descriptor unit");
        apb(0, REG_MEM + 8'h10, 0);
        chk(rd, 32'h50, "idle address kept");
        $display("single test done");
    endtask
    task automatic t_block();
        apb(1, REG_GRP0, 32'h3);
        apb(1, REG_MEM, 32'h60);
        apb(1, REG_CNT, 32'h2);
        apb(1, REG_MEM + 8'h10, 32'h90);
        apb(1, REG_CNT + 8'h10, 32'h2);
        apb(1, REG_CTRL + 8'h10, 0);
        apb(1, REG_CTRL, 32'h1683);
        pulse(11, 4);
        chk(32'(n_lock != 0), 32'h1, "bus held inside the block");
        chk(32'(bus_lock), 32'h0, "bus released at block end");
        chk(32'(fdc_mem_model_i.mem[8'h93]), 32'h39, "word unit upper byte");
        apb(0, REG_MEM + 8'h10, 0);
        chk(rd, 32'h90, "block area reloaded");
        apb(0, REG_MEM, 0);
        chk(rd, 32'h64, "other side keeps advancing");
        apb(0, REG_CNT, 0);
        chk(rd, 32'h1, "one block left");
        chk(32'(irq_cpu), 32'h0, "no completion mid run");
        pulse(11, 4);
        chk(32'(fdc_mem_model_i.mem[8'h90]), 32'h3E, "second block at area start");
        chk(32'(irq_cpu), 32'h1, "block run complete");
        $display("block test done");
    endtask
    // reset, then scenarios
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_seq();
        t_rep();
        t_single();
        t_block();
        stop_test();
    end
endmodule // fdc_dma_test

//--- tb/fdc_mem_model.sv
// system bus memory partner that also captures the acknowledge-strobed device data
module fdc_mem_model import fdc_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus from the controller
    input wire logic bus_req_i,
    input wire fdc_bus_s bus_i,
    input wire logic [NCH-1:0] strobe_i,
    output logic [15:0] rdata_o,
    output logic ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [1:0] wait_cnt;
    logic slow;
    logic [NCH-1:0] last_strobe;
    logic [23:0] last_addr;
    logic [15:0] dev_data;
    int n_ack;
    wire logic [7:0] a = bus_i.addr[7:0];
    // known fill pattern
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    // answer after no wait or a two-cycle wait, alternating
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            wait_cnt <= 2'h0;
            slow <= 1'b0;
            rdata_o <= 16'hA5A5;
            n_ack <= 0;
        end else begin
            ack_o <= 1'b0;
            rdata_o <= ~rdata_o; // released bus never shows stale data
            if (ack_o && bus_req_i) begin
                n_ack <= n_ack + 1;
                last_strobe <= strobe_i;
                last_addr <= bus_i.addr;
                if (strobe_i != 4'h0 && !bus_i.we) dev_data <= rdata_o;
                if (bus_i.we) mem[a] <= bus_i.wdata[7:0];
                if (bus_i.we && bus_i.word) mem[a + 8'h01] <= bus_i.wdata[15:8];
                slow <= !slow;
            end else if (bus_req_i) begin
                if (wait_cnt == (slow ? 2'h2 : 2'h0)) begin
                    ack_o <= 1'b1;
                    rdata_o <= {mem[a + 8'h01], mem[a]};
                    wait_cnt <= 2'h0;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end
        end
    end
endmodule // fdc_mem_model
